// ---- logic/adc_fault_defs.vh ----
// Purpose: Constants for the converter fault-status register group
// Assumes: Byte-wide registers reached through the serial command decoder
// Notes:   Offsets are register addresses as seen by serial read commands
`ifndef ADC_FAULT_DEFS_VH
`define ADC_FAULT_DEFS_VH

// Register addresses
`define ADDR_WIDTH          5
`define OFF_FAULT_SUMMARY   5'h02
`define OFF_POS_INPUT_FAULT 5'h03
`define OFF_NEG_INPUT_FAULT 5'h04
`define OFF_SERIAL_PORT     5'h05

// Reset value of every register in the group, except serial port status bit 2
`define FAULT_REG_RESET     8'h00

// Summary register bit positions
`define BIT_RESERVED        7
`define BIT_BAD_COMMAND     6
`define BIT_SERIAL_PORT     5
`define BIT_INPUT_RANGE     4
`define BIT_FRAME_TIMEOUT   3
`define BIT_REALIGN         2
`define BIT_RESULT_OVERRUN  1
`define BIT_INPUT_INTEGRITY 0

// Serial port status bit positions
`define BIT_SP_STARTUP      2
`define BIT_SP_CHIP_SELECT  1
`define BIT_SP_FRAME        0

// Captured interface-mode pin code for synchronous slave mode
`define MODE_SYNC_SLAVE     2'h2

// Channel count of the full variant
`define MAX_CHANNELS        4

// Serial clock edge counter width
`define FRAME_COUNT_WIDTH   10

`endif

// ---- logic/flag_cell.v ----
// Purpose: Group of sticky fault flags
// Assumes: clkEn gates every update
// Notes:   Set has priority over clear so no event is lost
`timescale 1ns/1ps
`default_nettype none

module flag_cell #(
  parameter WIDTH = 1
) (
  input  wire             mclk,
  input  wire             rst_n,
  input  wire             clkEn,
  input  wire [WIDTH-1:0] setIn,
  input  wire [WIDTH-1:0] clrIn,
  output reg  [WIDTH-1:0] flag
);

  wire [WIDTH-1:0] next_flag;

  assign next_flag = setIn | (flag & ~clrIn);

  always @(posedge mclk) begin
    if (!rst_n) begin
      flag <= {WIDTH{1'b0}};
    end else if (clkEn) begin
      flag <= next_flag;
    end
  end

endmodule

`default_nettype wire

// ---- logic/frame_clock_checker.v ----
// Purpose: Detects frames that end with too few serial clock edges
// Assumes: frameStart, frameEnd and sclkRise are single-cycle mclk pulses
// Notes:   frameShort is a one-cycle pulse after frameEnd
`timescale 1ns/1ps
`default_nettype none
`include "adc_fault_defs.vh"

module frame_clock_checker #(
  parameter CW = `FRAME_COUNT_WIDTH
) (
  input  wire          mclk,
  input  wire          rst_n,
  input  wire          clkEn,
  input  wire          frameStart,
  input  wire          frameEnd,
  input  wire          sclkRise,
  input  wire [CW-1:0] needEdges,
  output reg           frameShort
);

  reg  [CW-1:0] edgeCount;
  reg           inFrame;
  wire [CW-1:0] next_edgeCount;

  // Saturate so a long frame never wraps into a short count
  assign next_edgeCount = (&edgeCount) ? edgeCount : edgeCount + {{(CW-1){1'b0}}, 1'b1};

  always @(posedge mclk) begin
    if (!rst_n) begin
      edgeCount  <= {CW{1'b0}};
      inFrame    <= 1'b0;
      frameShort <= 1'b0;
    end else if (clkEn) begin
      frameShort <= 1'b0;
      if (frameStart) begin
        inFrame   <= 1'b1;
        edgeCount <= {CW{1'b0}};
      end else if (inFrame) begin
        if (frameEnd) begin
          inFrame    <= 1'b0;
          frameShort <= ((sclkRise ? next_edgeCount : edgeCount) < needEdges);
        end else if (sclkRise) begin
          edgeCount <= next_edgeCount;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- logic/adc_fault_status_regs.v ----
// Purpose: Fault summary, input threshold and serial port status registers
// Assumes: An external command decoder classifies commands and issues reads
// Notes:   All outputs are registered; clkEn low freezes all state
`timescale 1ns/1ps
`default_nettype none
`include "adc_fault_defs.vh"

// Operation
// - A no-operation command returns the fault summary register as its response.
// - Summary bit 7 is reserved and always reads zero.
// - Unrecognised commands are ignored and set the bad command flag.
// - When locked, only lock, unlock, no-op or multi-read avoid the bad command flag.
// - Serial port fault follows serial port status; clears on reading that register.
// - Input range fault follows threshold flags; clears after both are read.
// - Frame timeout sets on watchdog expiry; clears after summary read back.
// - Realign fault sets on a resynchronisation reset of the signal path in synchronous slave mode.
// - Result overrun sets when new data arrive during shifting out; auto-clears.
// - Integrity fault sets on uncorrectable Hamming error or failed CRC.
// - Faulty commands are discarded; integrity flag clears on serial port read.
// - Positive fault register holds channel flags in bits 3:0, upper bits zero.
// - Negative fault register holds channel flags in bits 3:0, upper bits zero.
// - On the two-channel variant channel 3 and 4 flags read zero.
// - Every register of the group resets to zero, except serial port status bit 2, which follows startupFault.
// - A frame with too few serial clock edges flags a frame fault.
// - Synchronous slave mode is the captured mode pin code 10.
module adc_fault_status_regs #(
  parameter NUM_CH = `MAX_CHANNELS,
  parameter CW     = `FRAME_COUNT_WIDTH
) (
  input  wire                    mclk,
  input  wire                    rst_n,
  input  wire                    clkEn,
  input  wire                    cmdStrobe,
  input  wire                    cmdKnown,
  input  wire                    cmdIsNull,
  input  wire                    cmdLockSafe,
  input  wire                    lockedState,
  input  wire                    hammingEnable,
  input  wire                    hammingUncorrectable,
  input  wire                    crcFail,
  input  wire                    rdReq,
  input  wire [`ADDR_WIDTH-1:0]  rdAddr,
  input  wire                    frameStart,
  input  wire                    frameEnd,
  input  wire                    sclkRise,
  input  wire [CW-1:0]           needEdges,
  input  wire                    chipSelectFault,
  input  wire                    startupFault,
  input  wire                    watchdogExpired,
  input  wire                    resyncEvent,
  input  wire [1:0]              interfaceModePinState,
  input  wire                    newDataReady,
  input  wire                    shiftOutBusy,
  input  wire [`MAX_CHANNELS-1:0] posOverThreshold,
  input  wire [`MAX_CHANNELS-1:0] negOverThreshold,
  output reg  [7:0]              rdData,
  output reg                     rdValid,
  output reg                     cmdAccept,
  output reg                     syncSlaveMode
);

  // Channels absent on a narrower variant are held at zero
  localparam [`MAX_CHANNELS-1:0] CH_MASK =
    (NUM_CH >= `MAX_CHANNELS) ? {`MAX_CHANNELS{1'b1}} :
    ~({`MAX_CHANNELS{1'b1}} << NUM_CH);

  // Transfer decode
  wire nullCmd;
  wire sumXfer;
  wire posXfer;
  wire negXfer;
  wire spXfer;

  // Fault events
  wire integrityEvent;
  wire lockBlocked;
  wire badCmdEvent;
  wire overrunEvent;
  wire realignEvent;
  wire frameShort;
  wire rangeEvent;
  wire rangeClear;

  // Stored flags
  wire                     badCmdFlag;
  wire                     spFaultFlag;
  wire                     rangeFlag;
  wire                     timeoutFlag;
  wire                     realignFlag;
  wire                     overrunFlag;
  wire                     integrityFlag;
  wire                     frameFaultFlag;
  wire                     csFaultFlag;
  wire [`MAX_CHANNELS-1:0] posFlags;
  wire [`MAX_CHANNELS-1:0] negFlags;

  reg                      posReadSeen;
  reg                      negReadSeen;

  // Assembled register images
  wire [7:0] summaryReg;
  wire [7:0] posReg;
  wire [7:0] negReg;
  wire [7:0] spStatusReg;

  function [7:0] read_mux;
    input [`ADDR_WIDTH-1:0] addr;
    input [7:0]             sumV;
    input [7:0]             posV;
    input [7:0]             negV;
    input [7:0]             spV;
    begin
      case (addr)
        `OFF_FAULT_SUMMARY:   read_mux = sumV;
        `OFF_POS_INPUT_FAULT: read_mux = posV;
        `OFF_NEG_INPUT_FAULT: read_mux = negV;
        `OFF_SERIAL_PORT:     read_mux = spV;
        default:              read_mux = `FAULT_REG_RESET;
      endcase
    end
  endfunction

  function is_xfer;
    input                   req;
    input [`ADDR_WIDTH-1:0] addr;
    input [`ADDR_WIDTH-1:0] target;
    begin
      is_xfer = req && (addr == target);
    end
  endfunction

  // Command classification
  assign integrityEvent = (hammingUncorrectable && hammingEnable) || crcFail;
  assign lockBlocked    = lockedState && !cmdLockSafe;
  assign badCmdEvent    = cmdStrobe && !integrityEvent &&
                          (!cmdKnown || lockBlocked);
  assign nullCmd        = cmdStrobe && cmdKnown && cmdIsNull &&
                          !integrityEvent;

  // A register transfer completes on the cycle its request is taken
  assign sumXfer = is_xfer(rdReq, rdAddr, `OFF_FAULT_SUMMARY) || nullCmd;
  assign posXfer = is_xfer(rdReq, rdAddr, `OFF_POS_INPUT_FAULT);
  assign negXfer = is_xfer(rdReq, rdAddr, `OFF_NEG_INPUT_FAULT);
  assign spXfer  = is_xfer(rdReq, rdAddr, `OFF_SERIAL_PORT);

  // Signal path events
  assign overrunEvent = newDataReady && shiftOutBusy;
  assign realignEvent = resyncEvent &&
                        (interfaceModePinState == `MODE_SYNC_SLAVE);
  assign rangeEvent   = |((posOverThreshold | negOverThreshold) & CH_MASK);
  assign rangeClear   = (posXfer || posReadSeen) && (negXfer || negReadSeen);

  frame_clock_checker #(
    .CW         (CW)
  ) u_frame_check (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .frameStart (frameStart),
    .frameEnd   (frameEnd),
    .sclkRise   (sclkRise),
    .needEdges  (needEdges),
    .frameShort (frameShort)
  );

  // Summary flags; set wins so a persisting fault re-asserts at once
  flag_cell #(.WIDTH(1)) u_badcmd (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clkEn (clkEn),
    .setIn (badCmdEvent),
    .clrIn (sumXfer),
    .flag  (badCmdFlag)
  );

  flag_cell #(.WIDTH(1)) u_spfault (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clkEn (clkEn),
    // Set from the status sources, so a status read is not overridden by the stale bits
    .setIn (startupFault | chipSelectFault | frameShort),
    .clrIn (spXfer),
    .flag  (spFaultFlag)
  );

  flag_cell #(.WIDTH(1)) u_range (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clkEn (clkEn),
    .setIn (rangeEvent),
    .clrIn (rangeClear),
    .flag  (rangeFlag)
  );

  flag_cell #(.WIDTH(1)) u_timeout (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clkEn (clkEn),
    .setIn (watchdogExpired),
    .clrIn (sumXfer),
    .flag  (timeoutFlag)
  );

  flag_cell #(.WIDTH(1)) u_realign (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clkEn (clkEn),
    .setIn (realignEvent),
    .clrIn (sumXfer),
    .flag  (realignFlag)
  );

  flag_cell #(.WIDTH(1)) u_overrun (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clkEn (clkEn),
    .setIn (overrunEvent),
    .clrIn (sumXfer),
    .flag  (overrunFlag)
  );

  flag_cell #(.WIDTH(1)) u_integrity (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clkEn (clkEn),
    .setIn (integrityEvent),
    .clrIn (spXfer),
    .flag  (integrityFlag)
  );

  // Serial port status flags
  flag_cell #(.WIDTH(2)) u_spbits (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clkEn (clkEn),
    .setIn ({chipSelectFault, frameShort}),
    .clrIn ({spXfer, spXfer}),
    .flag  ({csFaultFlag, frameFaultFlag})
  );

  // Channel threshold flags hold until their own register is read
  flag_cell #(.WIDTH(`MAX_CHANNELS)) u_posch (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clkEn (clkEn),
    .setIn (posOverThreshold & CH_MASK),
    .clrIn ({`MAX_CHANNELS{posXfer}}),
    .flag  (posFlags)
  );

  flag_cell #(.WIDTH(`MAX_CHANNELS)) u_negch (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clkEn (clkEn),
    .setIn (negOverThreshold & CH_MASK),
    .clrIn ({`MAX_CHANNELS{negXfer}}),
    .flag  (negFlags)
  );

  // Track which threshold registers were read since the range flag last cleared
  always @(posedge mclk) begin
    if (!rst_n) begin
      posReadSeen <= 1'b0;
      negReadSeen <= 1'b0;
    end else if (clkEn) begin
      if (rangeClear) begin
        posReadSeen <= 1'b0;
        negReadSeen <= 1'b0;
      end else begin
        posReadSeen <= posReadSeen | posXfer;
        negReadSeen <= negReadSeen | negXfer;
      end
    end
  end

  // Register images
  assign summaryReg = {1'b0,
                       badCmdFlag,
                       spFaultFlag,
                       rangeFlag,
                       timeoutFlag,
                       realignFlag,
                       overrunFlag,
                       integrityFlag};

  assign posReg = {4'h0, posFlags & CH_MASK};
  assign negReg = {4'h0, negFlags & CH_MASK};

  assign spStatusReg = {5'h00, startupFault, csFaultFlag, frameFaultFlag};

  // Read answers, command acceptance and mode output
  always @(posedge mclk) begin
    if (!rst_n) begin
      rdData        <= `FAULT_REG_RESET;
      rdValid       <= 1'b0;
      cmdAccept     <= 1'b0;
      syncSlaveMode <= 1'b0;
    end else if (clkEn) begin
      rdValid       <= 1'b0;
      cmdAccept     <= 1'b0;
      syncSlaveMode <= (interfaceModePinState == `MODE_SYNC_SLAVE);
      if (cmdStrobe) begin
        cmdAccept <= cmdKnown && !lockBlocked && !integrityEvent;
      end
      if (nullCmd) begin
        rdData  <= summaryReg;
        rdValid <= 1'b1;
      end else if (rdReq) begin
        rdData  <= read_mux(rdAddr, summaryReg, posReg, negReg, spStatusReg);
        rdValid <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- verif/fault_regs_checker_assertions.sv ----
// Purpose: Port-level checks for the fault register group
// Assumes: Bound to every instance of the register block, whatever its parameters
// Notes:   Answers land one cycle after the taking edge
`timescale 1ns/1ps
`default_nettype none
`include "adc_fault_defs.vh"

module fault_regs_checker (
  input wire                   mclk,
  input wire                   rst_n,
  input wire                   clkEn,
  input wire                   cmdStrobe,
  input wire                   cmdKnown,
  input wire                   cmdIsNull,
  input wire                   cmdLockSafe,
  input wire                   lockedState,
  input wire                   crcFail,
  input wire                   hammingUncorrectable,
  input wire                   rdReq,
  input wire [`ADDR_WIDTH-1:0] rdAddr,
  input wire [1:0]             interfaceModePinState,
  input wire [7:0]             rdData,
  input wire                   rdValid,
  input wire                   cmdAccept,
  input wire                   syncSlaveMode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire take = clkEn && cmdStrobe;
  wire clean = !crcFail && !hammingUncorrectable;

  chk_null_answers:
  assert property (take && cmdIsNull && cmdKnown && clean |=> rdValid)
    else $error("null command got no answer");
  chk_answer_cause:
  assert property (rdValid && $past(clkEn) |-> $past(rdReq || cmdStrobe))
    else $error("answer without request");
  chk_reserved_zero:
  assert property (rdValid |-> !rdData[7])
    else $error("bit 7 read as one");
  chk_unknown_refused:
  assert property (take && !cmdKnown |=> !cmdAccept)
    else $error("unknown command executed");
  chk_good_accepted:
  assert property (take && cmdKnown && (!lockedState || cmdLockSafe) && clean |=> cmdAccept)
    else $error("valid command dropped");
  chk_lock_blocks:
  assert property (take && lockedState && !cmdLockSafe |=> !cmdAccept)
    else $error("locked command executed");
  chk_faulty_discarded:
  assert property (take && crcFail |=> !cmdAccept)
    else $error("faulty command executed");
  chk_pos_upper_zero:
  assert property (rdValid && $past(clkEn) &&
    $past(rdReq && !cmdStrobe && rdAddr == `OFF_POS_INPUT_FAULT)
    |-> rdData[7:4] == 4'h0) else $error("positive upper bits set");
  chk_neg_upper_zero:
  assert property (rdValid && $past(clkEn) &&
    $past(rdReq && !cmdStrobe && rdAddr == `OFF_NEG_INPUT_FAULT)
    |-> rdData[7:4] == 4'h0) else $error("negative upper bits set");
  chk_mode_follows:
  assert property ($past(rst_n) && $past(clkEn)
    |-> syncSlaveMode == ($past(interfaceModePinState) == `MODE_SYNC_SLAVE))
    else $error("mode flag wrong");
  chk_reset_clears:
  assert property (disable iff (1'b0) !rst_n |=> !rdValid && !cmdAccept && rdData == 8'h00)
    else $error("outputs not cleared by reset");
endmodule

bind adc_fault_status_regs fault_regs_checker chk (
  .mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .cmdStrobe(cmdStrobe), .cmdKnown(cmdKnown),
  .cmdIsNull(cmdIsNull), .cmdLockSafe(cmdLockSafe), .lockedState(lockedState),
  .crcFail(crcFail), .hammingUncorrectable(hammingUncorrectable), .rdReq(rdReq),
  .rdAddr(rdAddr), .interfaceModePinState(interfaceModePinState), .rdData(rdData),
  .rdValid(rdValid), .cmdAccept(cmdAccept), .syncSlaveMode(syncSlaveMode));
`default_nettype wire

// ---- verif/host_model.sv ----
// Purpose: Host side issuing commands and register reads
// Assumes: Tasks are entered at a falling edge of mclk
// Notes:   Released lines show inverted values so stale data is not mistaken
`timescale 1ns/1ps
`default_nettype none
`include "adc_fault_defs.vh"

module host_model (
  input  wire                   mclk,
  input  wire [7:0]             rdData,
  input  wire                   rdValid,
  input  wire                   cmdAccept,
  output reg                    cmdStrobe,
  output reg                    cmdKnown,
  output reg                    cmdIsNull,
  output reg                    cmdLockSafe,
  output reg                    rdReq,
  output reg  [`ADDR_WIDTH-1:0] rdAddr
);
  initial begin
    cmdStrobe = 1'b0;
    cmdKnown = 1'b0;
    cmdIsNull = 1'b0;
    cmdLockSafe = 1'b0;
    rdReq = 1'b0;
    rdAddr = 5'h1f;
  end

  task rd(input [`ADDR_WIDTH-1:0] a, output [7:0] d);
    begin
      rdReq = 1'b1;
      rdAddr = a;
      @(negedge mclk);
      rdReq = 1'b0;
      rdAddr = ~a;
      d = rdValid ? rdData : 8'hxx;
      @(negedge mclk);
    end
  endtask

  task cmd(input k, input n, input s, output acc, output [7:0] d);
    begin
      cmdStrobe = 1'b1;
      cmdKnown = k;
      cmdIsNull = n;
      cmdLockSafe = s;
      @(negedge mclk);
      cmdStrobe = 1'b0;
      cmdKnown = ~k;
      cmdIsNull = ~n;
      cmdLockSafe = ~s;
      acc = cmdAccept;
      d = rdValid ? rdData : 8'hxx;
      @(negedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_adc_fault_status_regs.sv ----
// Purpose: Self-checking bench for the fault register group
// Assumes: Inputs change at falling edges only
// Notes:   Event inputs share one vector so pulses stay one cycle wide
`timescale 1ns/1ps
`default_nettype none
`include "adc_fault_defs.vh"

module tb_adc_fault_status_regs;
  reg                    mclk;
  reg                    rst_n;
  reg                    clkEn;
  reg                    startup;
  reg                    lockedState;
  reg                    hammingEnable;
  reg                    shiftOutBusy;
  reg  [1:0]             mode;
  reg  [3:0]             pos;
  reg  [3:0]             neg;
  reg  [8:0]             ev;
  reg  [9:0]             needEdges;
  reg  [7:0]             d;
  reg                    acc;
  wire [7:0]             rdData;
  wire [7:0]             rdData2;
  wire [`ADDR_WIDTH-1:0] rdAddr;
  wire                   rdValid, cmdAccept, syncSlaveMode, rdReq;
  wire                   cmdStrobe, cmdKnown, cmdIsNull, cmdLockSafe;
  integer                failures, checks_done, i;

  adc_fault_status_regs uut (
    .mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .cmdStrobe(cmdStrobe), .cmdKnown(cmdKnown),
    .cmdIsNull(cmdIsNull), .cmdLockSafe(cmdLockSafe), .lockedState(lockedState),
    .hammingEnable(hammingEnable), .hammingUncorrectable(ev[5]), .crcFail(ev[4]),
    .rdReq(rdReq), .rdAddr(rdAddr), .frameStart(ev[6]), .frameEnd(ev[8]),
    .sclkRise(ev[7]), .needEdges(needEdges), .chipSelectFault(ev[3]), .startupFault(startup),
    .watchdogExpired(ev[0]), .resyncEvent(ev[1]), .interfaceModePinState(mode),
    .newDataReady(ev[2]), .shiftOutBusy(shiftOutBusy), .posOverThreshold(pos),
    .negOverThreshold(neg), .rdData(rdData), .rdValid(rdValid), .cmdAccept(cmdAccept),
    .syncSlaveMode(syncSlaveMode));

  // Two-channel variant sharing every input; only its read data is compared
  adc_fault_status_regs #(.NUM_CH(2)) uut2 (
    .mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .cmdStrobe(cmdStrobe), .cmdKnown(cmdKnown),
    .cmdIsNull(cmdIsNull), .cmdLockSafe(cmdLockSafe), .lockedState(lockedState),
    .hammingEnable(hammingEnable), .hammingUncorrectable(ev[5]), .crcFail(ev[4]),
    .rdReq(rdReq), .rdAddr(rdAddr), .frameStart(ev[6]), .frameEnd(ev[8]),
    .sclkRise(ev[7]), .needEdges(needEdges), .chipSelectFault(ev[3]), .startupFault(startup),
    .watchdogExpired(ev[0]), .resyncEvent(ev[1]), .interfaceModePinState(mode),
    .newDataReady(ev[2]), .shiftOutBusy(shiftOutBusy), .posOverThreshold(pos),
    .negOverThreshold(neg), .rdData(rdData2), .rdValid(), .cmdAccept(),
    .syncSlaveMode());

  host_model host (
    .mclk(mclk), .rdData(rdData), .rdValid(rdValid), .cmdAccept(cmdAccept),
    .cmdStrobe(cmdStrobe), .cmdKnown(cmdKnown), .cmdIsNull(cmdIsNull),
    .cmdLockSafe(cmdLockSafe), .rdReq(rdReq), .rdAddr(rdAddr));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task rdc(input [`ADDR_WIDTH-1:0] a, input [7:0] e);
    begin
      host.rd(a, d);
      chk(d, e);
    end
  endtask

  task pulse(input [8:0] m);
    begin
      ev = m;
      @(negedge mclk);
      ev = 9'h000;
      @(negedge mclk);
    end
  endtask

  task end_of_test;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask

  initial begin
    #20000;
    failures = failures + 1;
    end_of_test;
  end

  initial begin
    failures = 0;
    checks_done = 0;
    rst_n = 1'b0;
    lockedState = 1'b0;
    hammingEnable = 1'b1;
    shiftOutBusy = 1'b0;
    mode = 2'h0;
    clkEn = 1'b1;
    startup = 1'b0;
    pos = 4'h0;
    neg = 4'h0;
    ev = 9'h000;
    needEdges = 10'h004;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    for (i = 2; i < 7; i = i + 1) rdc(i[4:0], 8'h00);
    host.cmd(1'b0, 1'b0, 1'b0, acc, d);
    chk({7'h00, acc}, 8'h00);
    host.cmd(1'b1, 1'b1, 1'b1, acc, d);
    chk(d, 8'h40);
    host.cmd(1'b1, 1'b1, 1'b1, acc, d);
    chk(d, 8'h00);
    lockedState = 1'b1;
    host.cmd(1'b1, 1'b0, 1'b0, acc, d);
    chk({7'h00, acc}, 8'h00);
    host.cmd(1'b1, 1'b0, 1'b1, acc, d);
    chk({7'h00, acc}, 8'h01);
    rdc(5'h02, 8'h40);
    lockedState = 1'b0;
    shiftOutBusy = 1'b1;
    mode = 2'h2;
    // Watchdog, resync and overrun events, each auto-cleared by one summary read
    for (i = 0; i < 3; i = i + 1) begin
      pulse(9'h001 << i);
      rdc(5'h02, 8'h08 >> i);
      rdc(5'h02, 8'h00);
    end
    // Resync outside synchronous slave mode must leave the flag clear
    mode = 2'h0;
    pulse(9'h002);
    rdc(5'h02, 8'h00);
    shiftOutBusy = 1'b0;
    ev = 9'h010;
    host.cmd(1'b1, 1'b0, 1'b1, acc, d);
    ev = 9'h000;
    chk({7'h00, acc}, 8'h00);
    rdc(5'h02, 8'h01);
    rdc(5'h02, 8'h01);
    rdc(5'h05, 8'h00);
    rdc(5'h02, 8'h00);
    pulse(9'h020);
    rdc(5'h02, 8'h01);
    rdc(5'h05, 8'h00);
    pulse(9'h008);
    rdc(5'h02, 8'h20);
    rdc(5'h02, 8'h20);
    rdc(5'h05, 8'h02);
    rdc(5'h02, 8'h00);
    // Frame with two serial clock edges where four are needed
    pulse(9'h040);
    pulse(9'h080);
    pulse(9'h080);
    pulse(9'h100);
    repeat (2) @(negedge mclk);
    rdc(5'h02, 8'h20);
    rdc(5'h05, 8'h01);
    rdc(5'h05, 8'h00);
    startup = 1'b1;
    @(negedge mclk);
    rdc(5'h02, 8'h20);
    rdc(5'h05, 8'h04);
    rdc(5'h02, 8'h20);
    startup = 1'b0;
    rdc(5'h05, 8'h00);
    rdc(5'h02, 8'h00);
    pos = 4'h5;
    neg = 4'ha;
    @(negedge mclk);
    pos = 4'h0;
    neg = 4'h0;
    @(negedge mclk);
    rdc(5'h02, 8'h10);
    rdc(5'h03, 8'h05);
    chk(rdData2, 8'h01);
    rdc(5'h02, 8'h10);
    rdc(5'h04, 8'h0a);
    chk(rdData2, 8'h02);
    rdc(5'h02, 8'h00);
    rdc(5'h03, 8'h00);
    mode = 2'h2;
    @(negedge mclk);
    chk({7'h00, syncSlaveMode}, 8'h01);
    mode = 2'h1;
    @(negedge mclk);
    chk({7'h00, syncSlaveMode}, 8'h00);
    // A frozen block ignores events
    clkEn = 1'b0;
    pulse(9'h001);
    clkEn = 1'b1;
    rdc(5'h02, 8'h00);
    pulse(9'h001);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    rdc(5'h02, 8'h00);
    end_of_test;
  end
endmodule
`default_nettype wire
